// ==== hdl/bwsr_defs.vh ====
// Register addresses, field positions, reset values and timing counts of the bus and wake status bank
`ifndef BWSR_DEFS_VH
`define BWSR_DEFS_VH
`define BWSR_ADDR_PRIOR_STATE_FIELD      7'h42
`define BWSR_ADDR_BUS_STAT      7'h43
`define BWSR_ADDR_WAKE_SRC      7'h44
`define BWSR_ADDR_WAKE_LVL      7'h45
`define BWSR_RESET_VALUE        16'h0000
`define BWSR_BUS_CAN_TIMEOUT_FLAG_BIT      4
`define BWSR_BUS_SELECTIVE_WAKE_SYS_ERROR_BIT     3
`define BWSR_BUS_FAIL_HI        2
`define BWSR_BUS_FAIL_LO        1
`define BWSR_BUS_UV_BIT         0
`define BWSR_WK_BUS_BIT         9
`define BWSR_WK_TMR2_BIT        8
`define BWSR_WK_TMR1_BIT        7
`define BWSR_WK_PIN5_BIT        4
`define BWSR_WK_PIN4_BIT        3
`define BWSR_DEV_CRC_STAT_BIT   9
`define BWSR_DEV_CRC_FAIL_BIT   8
`define BWSR_DEV_PRIOR_HI       7
`define BWSR_DEV_PRIOR_LO       6
`define BWSR_DEV_SWDEV_BIT      4
`define BWSR_DEV_WD_HI          3
`define BWSR_DEV_WD_LO          2
`define BWSR_DEV_SPI_FAIL_BIT   1
`define BWSR_DEV_FAIL_BIT       0
`define BWSR_FAIL_NONE          2'h0
`define BWSR_FAIL_TSD           2'h1
`define BWSR_FAIL_TXD_DOM       2'h2
`define BWSR_FAIL_BUS_DOM       2'h3
`define BWSR_PRIOR_CLEARED      2'h0
`define BWSR_PRIOR_RESTART      2'h1
`define BWSR_PRIOR_SLEEP        2'h2
`define BWSR_SWK_ERR_LIMIT      6'h20
`define BWSR_TX_ENABLE_NS       1000
`define BWSR_CLK_PERIOD_NS      10
`define BWSR_TX_ENABLE_CYCLES   ((`BWSR_TX_ENABLE_NS + `BWSR_CLK_PERIOD_NS - 1) / `BWSR_CLK_PERIOD_NS)
`endif

// ==== hdl/bwsr_status_bank.v ====
// Bus communication, wake source, wake level and device status register bank
`include "bwsr_defs.vh"

// Behaviour
// RULE1: Prior state reports sleep or failure path
// RULE2: Sleep attempt with wake flags reports sleep
// RULE3: Watchdog fails count; only self-cleared bits
// RULE4: Serial fail flag cleared only by host
// RULE5: CRC bits readable; frame CRC ignored
// RULE6: Bit 4 is clear-on-read timeout flag
// RULE7: Selective wake error gated by enable
// RULE8: Failure field codes ascending, clear-on-read
// RULE9: Bit 0 undervoltage, comparator in active modes
// RULE10: Transmit timeout recovers on high or off
// RULE11: Bus timeout recovers on recessive or off
// RULE12: Undervoltage recovers above threshold
// RULE13: Transmit resumes after recessive enable time
// RULE14: Timeout flag sets from silence, sticky
// RULE15: Interrupt on timeout when mask set
// RULE16: Timeout clear blocked until interrupt fall
// RULE17: Wake source flags at documented bits
// RULE18: Fail-safe entry clears wake sources
// RULE19: Wake level bits four and three
// RULE20: Levels follow in active modes
// RULE21: Cyclic modes hold last sampled level
// RULE22: Reserved bits read zero
// RULE23: Read returns value then clears
module bwsr_status_bank #(
    parameter TX_ENABLE_CYCLES = `BWSR_TX_ENABLE_CYCLES
) (
    // Clock and resets
    input  wire        clock_in,
    input  wire        reset_n_in,
    input  wire        soft_reset_in,
    input  wire        restart_reset_in,
    // Host register access, one pulse per decoded serial frame
    input  wire        read_strobe_in,
    input  wire        clear_strobe_in,
    input  wire [6:0]  address_in,
    output reg  [15:0] read_data_out,
    output reg         read_valid_out,
    // Operating mode of the device
    input  wire        mode_normal_in,
    input  wire        mode_stop_in,
    input  wire        mode_init_in,
    input  wire        mode_restart_in,
    input  wire        mode_cyclic_in,
    input  wire        sample_strobe_in,
    input  wire        fail_safe_entry_in,
    input  wire        leave_restart_in,
    input  wire        from_sleep_in,
    input  wire        from_failure_in,
    // Device status events
    input  wire        watchdog_fail_counter_event_in,
    input  wire        wd_good_service_in,
    input  wire        invalid_cmd_in,
    input  wire        crc_enabled_in,
    input  wire        crc_fail_event_in,
    input  wire        sw_dev_in,
    input  wire        failure_event_in,
    // Transceiver state
    input  wire        can_active_in,
    input  wire        can_wake_capable_in,
    input  wire        can_off_in,
    input  wire        can_tsd_in,
    input  wire        can_txd_in,
    input  wire        can_bus_recessive_in,
    input  wire        txd_dom_timeout_in,
    input  wire        bus_dom_timeout_in,
    input  wire        can_supply_low_in,
    // Selective wake
    input  wire        selective_wake_enable_in,
    input  wire        swk_config_error_in,
    input  wire [5:0]  swk_error_count_in,
    input  wire        can_silence_indication_in,
    input  wire        can_timeout_irq_mask_in,
    // Wake sources and pins
    input  wire        bus_wake_in,
    input  wire        timer_one_wake_in,
    input  wire        timer_two_wake_in,
    input  wire        pin_four_wake_in,
    input  wire        pin_five_wake_in,
    input  wire        pin_four_in,
    input  wire        pin_five_in,
    // Outputs to the rest of the device
    output reg         interrupt_out_n,
    output reg         tx_enable_out
);

    // Pin synchronisers; first stage feeds only the second
    reg [1:0] pin4_sync_reg;
    reg [1:0] pin5_sync_reg;
    reg [1:0] txd_sync_reg;
    reg [1:0] rec_sync_reg;

    reg [1:0]  prior_state_field_reg;
    reg [1:0]  watchdog_fail_counter_reg;
    reg        spi_fail_reg;
    reg        crc_fail_reg;
    reg        failure_reg;
    reg        can_timeout_flag_reg;
    reg        selective_wake_sys_error_reg;
    reg [1:0]  can_fail_reg;
    reg        can_supply_undervoltage_reg;
    reg [15:0] wake_flags_reg;
    reg        pin_four_level_reg;
    reg        pin_five_level_reg;
    reg        clear_block_reg;
    reg        silence_prev_reg;
    reg [15:0] tx_count_reg;
    reg        tx_recover_reg;

    wire rd_dev  = read_strobe_in && (address_in == `BWSR_ADDR_PRIOR_STATE_FIELD);
    wire rd_bus  = read_strobe_in && (address_in == `BWSR_ADDR_BUS_STAT);
    wire rd_wake = read_strobe_in && (address_in == `BWSR_ADDR_WAKE_SRC);
    wire any_rst = soft_reset_in || restart_reset_in;

    // Two-flop synchronisers for pin levels
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin4_sync_reg <= 2'h0;
            pin5_sync_reg <= 2'h0;
            txd_sync_reg  <= 2'h3;
            rec_sync_reg  <= 2'h3;
        end else begin
            pin4_sync_reg <= {pin4_sync_reg[0], pin_four_in};
            pin5_sync_reg <= {pin5_sync_reg[0], pin_five_in};
            txd_sync_reg  <= {txd_sync_reg[0], can_txd_in};
            rec_sync_reg  <= {rec_sync_reg[0], can_bus_recessive_in};
        end
    end

    wire txd_high = txd_sync_reg[1];
    wire bus_rec  = rec_sync_reg[1];
    wire can_idle = can_wake_capable_in || can_off_in;

    // Device status: restart keeps these, soft reset clears
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prior_state_field_reg     <= `BWSR_PRIOR_CLEARED;
            watchdog_fail_counter_reg <= 2'h0;
            spi_fail_reg              <= 1'b0;
            crc_fail_reg              <= 1'b0;
            failure_reg               <= 1'b0;
        end else if (soft_reset_in) begin
            prior_state_field_reg     <= `BWSR_PRIOR_CLEARED;
            watchdog_fail_counter_reg <= 2'h0;
            spi_fail_reg              <= 1'b0;
            crc_fail_reg              <= 1'b0;
            failure_reg               <= 1'b0;
        end else begin
            // RULE1 RULE2: record path on restart exit
            if (leave_restart_in && from_failure_in)
                prior_state_field_reg <= `BWSR_PRIOR_RESTART;
            else if (leave_restart_in && from_sleep_in)
                prior_state_field_reg <= `BWSR_PRIOR_SLEEP;
            else if (rd_dev && clear_strobe_in)
                prior_state_field_reg <= `BWSR_PRIOR_CLEARED;
            // RULE3: saturating counter, device clears itself
            if (watchdog_fail_counter_event_in && watchdog_fail_counter_reg != 2'h3)
                watchdog_fail_counter_reg <= watchdog_fail_counter_reg + 2'h1;
            else if (wd_good_service_in && !watchdog_fail_counter_event_in)
                watchdog_fail_counter_reg <= 2'h0;
            // RULE4: only host clear command, set wins
            if (invalid_cmd_in)
                spi_fail_reg <= 1'b1;
            else if (rd_dev && clear_strobe_in)
                spi_fail_reg <= 1'b0;
            if (crc_fail_event_in)
                crc_fail_reg <= 1'b1;
            else if (rd_dev && clear_strobe_in)
                crc_fail_reg <= 1'b0;
            if (failure_event_in)
                failure_reg <= 1'b1;
            else if (rd_dev && clear_strobe_in)
                failure_reg <= 1'b0;
        end
    end

    // Bus status flags
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            can_timeout_flag_reg         <= 1'b0;
            selective_wake_sys_error_reg <= 1'b0;
            can_fail_reg                 <= `BWSR_FAIL_NONE;
            can_supply_undervoltage_reg  <= 1'b0;
            silence_prev_reg             <= 1'b0;
        end else if (soft_reset_in) begin
            can_timeout_flag_reg         <= 1'b0;
            selective_wake_sys_error_reg <= 1'b0;
            can_fail_reg                 <= `BWSR_FAIL_NONE;
            can_supply_undervoltage_reg  <= 1'b0;
            silence_prev_reg             <= 1'b0;
        end else begin
            silence_prev_reg <= can_silence_indication_in;
            // RULE14 RULE6 RULE16 RULE23: sticky, clear gated by block
            if (selective_wake_enable_in && can_silence_indication_in && !silence_prev_reg)
                can_timeout_flag_reg <= 1'b1;
            else if (rd_bus && !clear_block_reg)
                can_timeout_flag_reg <= 1'b0;
            // RULE7: set only with selective wake enabled
            if (selective_wake_enable_in &&
                (swk_config_error_in || swk_error_count_in > `BWSR_SWK_ERR_LIMIT))
                selective_wake_sys_error_reg <= 1'b1;
            else if (rd_bus)
                selective_wake_sys_error_reg <= 1'b0;
            // RULE8: ascending codes, highest pending wins
            if (bus_dom_timeout_in)
                can_fail_reg <= `BWSR_FAIL_BUS_DOM;
            else if (txd_dom_timeout_in)
                can_fail_reg <= `BWSR_FAIL_TXD_DOM;
            else if (can_tsd_in)
                can_fail_reg <= `BWSR_FAIL_TSD;
            else if (rd_bus)
                can_fail_reg <= `BWSR_FAIL_NONE;
            // RULE9: comparator live only in active modes
            if (can_active_in && can_supply_low_in)
                can_supply_undervoltage_reg <= 1'b1;
            else if (rd_bus)
                can_supply_undervoltage_reg <= 1'b0;
        end
    end

    // RULE16: clear blocked from set until interrupt falls
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in)
            clear_block_reg <= 1'b0;
        else if (any_rst)
            clear_block_reg <= 1'b0;
        else if (selective_wake_enable_in && can_silence_indication_in && !silence_prev_reg)
            clear_block_reg <= can_timeout_irq_mask_in;
        else if (!interrupt_out_n)
            clear_block_reg <= 1'b0;
    end

    // RULE15: one-cycle low pulse in stop or normal
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in)
            interrupt_out_n <= 1'b1;
        else
            interrupt_out_n <= !(selective_wake_enable_in && can_silence_indication_in &&
                                 !silence_prev_reg && can_timeout_irq_mask_in &&
                                 (mode_stop_in || mode_normal_in));
    end

    // Transmitter path state: any failure holds it off
    wire fault_active = can_tsd_in ||
                        (txd_dom_timeout_in && !(txd_high || can_idle)) ||
                        (bus_dom_timeout_in && !(bus_rec || can_idle)) ||
                        (can_active_in && can_supply_low_in);

    // RULE10 RULE11 RULE12 RULE13: recover, then wait recessive time
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_recover_reg <= 1'b0;
            tx_count_reg   <= 16'h0000;
            tx_enable_out  <= 1'b1;
        end else if (fault_active) begin
            tx_recover_reg <= 1'b1;
            tx_count_reg   <= 16'h0000;
            tx_enable_out  <= 1'b0;
        end else if (tx_recover_reg) begin
            if (!txd_high) begin
                tx_count_reg <= 16'h0000;
            end else if (tx_count_reg >= TX_ENABLE_CYCLES[15:0] - 16'h1) begin
                tx_recover_reg <= 1'b0;
                tx_enable_out  <= 1'b1;
            end else begin
                tx_count_reg <= tx_count_reg + 16'h1;
            end
        end
    end

    // Wake sources; set wins over read clear
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_flags_reg <= `BWSR_RESET_VALUE;
        end else if (soft_reset_in || fail_safe_entry_in) begin
            // RULE18: fail-safe entry empties the register
            wake_flags_reg <= `BWSR_RESET_VALUE;
        end else begin
            // RULE17 RULE23: clear on read unless newly set
            wake_flags_reg[`BWSR_WK_BUS_BIT]  <= bus_wake_in || (wake_flags_reg[`BWSR_WK_BUS_BIT] && !rd_wake);
            wake_flags_reg[`BWSR_WK_TMR2_BIT] <= timer_two_wake_in ||
                                                 (wake_flags_reg[`BWSR_WK_TMR2_BIT] && !rd_wake);
            wake_flags_reg[`BWSR_WK_TMR1_BIT] <= timer_one_wake_in ||
                                                 (wake_flags_reg[`BWSR_WK_TMR1_BIT] && !rd_wake);
            wake_flags_reg[`BWSR_WK_PIN5_BIT] <= pin_five_wake_in ||
                                                 (wake_flags_reg[`BWSR_WK_PIN5_BIT] && !rd_wake);
            wake_flags_reg[`BWSR_WK_PIN4_BIT] <= pin_four_wake_in ||
                                                 (wake_flags_reg[`BWSR_WK_PIN4_BIT] && !rd_wake);
        end
    end

    // RULE20 RULE21: follow pins live or at each sample
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_four_level_reg <= 1'b0;
            pin_five_level_reg <= 1'b0;
        end else if (mode_cyclic_in ? sample_strobe_in
                     : (mode_normal_in || mode_stop_in || mode_init_in || mode_restart_in)) begin
            pin_four_level_reg <= pin4_sync_reg[1];
            pin_five_level_reg <= pin5_sync_reg[1];
        end
    end

    // Read mux; RULE22 reserved bits stay zero
    reg [15:0] read_next;
    always @* begin
        read_next = 16'h0000;
        case (address_in)
            `BWSR_ADDR_PRIOR_STATE_FIELD: begin
                // RULE5: CRC bits shown regardless of setting
                read_next[`BWSR_DEV_CRC_STAT_BIT] = crc_enabled_in;
                read_next[`BWSR_DEV_CRC_FAIL_BIT] = crc_fail_reg;
                read_next[`BWSR_DEV_PRIOR_HI:`BWSR_DEV_PRIOR_LO] = prior_state_field_reg;
                read_next[`BWSR_DEV_SWDEV_BIT] = sw_dev_in;
                read_next[`BWSR_DEV_WD_HI:`BWSR_DEV_WD_LO] = watchdog_fail_counter_reg;
                read_next[`BWSR_DEV_SPI_FAIL_BIT] = spi_fail_reg;
                read_next[`BWSR_DEV_FAIL_BIT] = failure_reg;
            end
            `BWSR_ADDR_BUS_STAT: begin
                read_next[`BWSR_BUS_CAN_TIMEOUT_FLAG_BIT]  = can_timeout_flag_reg;
                read_next[`BWSR_BUS_SELECTIVE_WAKE_SYS_ERROR_BIT] = selective_wake_sys_error_reg;
                read_next[`BWSR_BUS_FAIL_HI:`BWSR_BUS_FAIL_LO] = can_fail_reg;
                read_next[`BWSR_BUS_UV_BIT] = can_supply_undervoltage_reg;
            end
            `BWSR_ADDR_WAKE_SRC: begin
                read_next = wake_flags_reg;
            end
            `BWSR_ADDR_WAKE_LVL: begin
                // RULE19: registered pin levels, followed in active modes or last sampled
                read_next[`BWSR_WK_PIN5_BIT] = pin_five_level_reg;
                read_next[`BWSR_WK_PIN4_BIT] = pin_four_level_reg;
            end
            default: begin
                read_next = 16'h0000;
            end
        endcase
    end

    // Read data registered; value sampled before the clear lands
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            read_data_out  <= 16'h0000;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= read_strobe_in;
            if (read_strobe_in)
                read_data_out <= read_next;
        end
    end

endmodule

// ==== testbench/bwsr_checker_assertions.sv ====
// Concurrent checks on the ports of the bus and wake status bank
module bwsr_checker #(
    parameter TX_ENABLE_CYCLES = 5
) (
    // Clock and reset
    input wire        clock_in,
    input wire        reset_n_in,
    // Host access
    input wire        read_strobe_in,
    input wire [6:0]  address_in,
    input wire [15:0] read_data_out,
    input wire        read_valid_out,
    // Mode, pins and selective wake
    input wire        mode_normal_in,
    input wire        can_txd_in,
    input wire        selective_wake_enable_in,
    input wire        can_silence_indication_in,
    input wire        can_timeout_irq_mask_in,
    input wire        pin_five_in,
    // Device outputs
    input wire        interrupt_out_n,
    input wire        tx_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    // Read answers, reserved bits and pin levels
    a_read_answer: assert property (read_strobe_in |=> read_valid_out)
        else $error("read not answered");
    a_bus_reserved: assert property (read_strobe_in && address_in == 7'h43 |=> read_data_out[15:5] == 11'h000)
        else $error("bus status reserved bits set");
    a_wake_reserved: assert property (read_strobe_in && address_in == 7'h44 |=>
        {read_data_out[15:10], read_data_out[6:5], read_data_out[2:0]} == 11'h000)
        else $error("wake source reserved bits set");
    a_level_reserved: assert property (read_strobe_in && address_in == 7'h45 |=>
        {read_data_out[15:5], read_data_out[2:0]} == 14'h0000)
        else $error("wake level reserved bits set");
    a_level_follows: assert property ((mode_normal_in && pin_five_in)[*4] ##1
        (mode_normal_in && pin_five_in && read_strobe_in && address_in == 7'h45) |=> read_data_out[4])
        else $error("pin five level not shown");

    // Interrupt on a fresh timeout; a fresh flag is assumed, not seen here
    a_timeout_irq: assert property ($rose(can_silence_indication_in) && selective_wake_enable_in &&
        can_timeout_irq_mask_in && mode_normal_in |-> ##[1:6] !interrupt_out_n)
        else $error("no interrupt on timeout");
    a_irq_pulse: assert property ($fell(interrupt_out_n) |=> interrupt_out_n)
        else $error("interrupt pulse too long");

    // Transmitter returns only after a recessive spell
    a_tx_resume: assert property ($rose(tx_enable_out) |->
        can_txd_in && $past(can_txd_in, TX_ENABLE_CYCLES))
        else $error("transmitter enabled too early");
endmodule

// ==== testbench/bwsr_host_model.sv ====
// Host side model: register reads and the transmit data line
module bwsr_host_model (
    // Clock and answer
    input  wire         clock_in,
    input  wire  [15:0] read_data_out,
    input  wire         read_valid_out,
    // Requests
    output logic        host_strobe_out,
    output logic        host_clear_out,
    output logic [6:0]  host_addr_out,
    output logic        host_txd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle host; transmit line recessive
    initial begin
        host_strobe_out = 1'b0;
        host_clear_out = 1'b0;
        host_addr_out = 7'h00;
        host_txd_out = 1'b1;
    end

    // One read frame; ok stays low when no answer came
    task automatic read_reg(input logic [6:0] a, input logic c, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(negedge clock_in);
        host_strobe_out = 1'b1;
        host_clear_out = c;
        host_addr_out = a;
        for (int k = 0; k < 4 && !ok; k++) begin
            @(negedge clock_in);
            host_strobe_out = 1'b0;
            host_clear_out = 1'b0;
            // Released address must not look like a held one
            host_addr_out = ~a;
            if (read_valid_out === 1'b1) begin
                d = read_data_out;
                ok = 1'b1;
            end
        end
    endtask

    // recessive again after a dominant spell
    task automatic dominant(input int n);
        host_txd_out = 1'b0;
        repeat (n) @(negedge clock_in);
        host_txd_out = 1'b1;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the bus and wake status bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TX_EN = 5;
    logic        clock_in;
    logic        reset_n_in;
    logic [14:0] p;
    logic [22:0] l;
    logic [5:0]  swk_count;
    wire         strobe, clr, txd, read_valid_out, interrupt_out_n, tx_enable_out;
    wire  [6:0]  addr;
    wire  [15:0] read_data_out;
    int          n_mismatch, n_tests;

    // Pulses in p, levels in l
    bwsr_status_bank #(.TX_ENABLE_CYCLES(TX_EN)) i_bwsr_status_bank (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .soft_reset_in(p[13]), .restart_reset_in(p[14]), .read_strobe_in(strobe), .clear_strobe_in(clr),
        .address_in(addr), .read_data_out(read_data_out), .read_valid_out(read_valid_out), .mode_normal_in(l[0]),
        .mode_stop_in(l[1]), .mode_init_in(l[2]), .mode_restart_in(l[3]), .mode_cyclic_in(l[4]),
        .sample_strobe_in(p[7]), .fail_safe_entry_in(p[6]), .leave_restart_in(p[5]), .from_sleep_in(l[5]),
        .from_failure_in(l[6]), .watchdog_fail_counter_event_in(p[0]), .wd_good_service_in(p[1]), .invalid_cmd_in(p[2]),
        .crc_enabled_in(l[7]), .crc_fail_event_in(p[3]), .sw_dev_in(l[8]), .failure_event_in(p[4]),
        .can_active_in(l[9]), .can_wake_capable_in(l[10]), .can_off_in(l[11]), .can_tsd_in(l[12]),
        .can_txd_in(txd), .can_bus_recessive_in(l[13]), .txd_dom_timeout_in(l[14]), .bus_dom_timeout_in(l[15]),
        .can_supply_low_in(l[16]), .selective_wake_enable_in(l[17]), .swk_config_error_in(l[18]),
        .swk_error_count_in(swk_count), .can_silence_indication_in(l[19]), .can_timeout_irq_mask_in(l[20]),
        .bus_wake_in(p[8]), .timer_two_wake_in(p[9]), .timer_one_wake_in(p[10]), .pin_five_wake_in(p[11]),
        .pin_four_wake_in(p[12]), .pin_four_in(l[21]), .pin_five_in(l[22]), .interrupt_out_n(interrupt_out_n),
        .tx_enable_out(tx_enable_out));

    bwsr_host_model i_bwsr_host_model (.clock_in(clock_in), .read_data_out(read_data_out),
        .read_valid_out(read_valid_out), .host_strobe_out(strobe), .host_clear_out(clr), .host_addr_out(addr),
        .host_txd_out(txd));

    // Verdict and end of run
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compare one value
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask

    // Read a register, optionally clearing, and compare; a missing answer ends the run
    task automatic chk(input logic [6:0] a, input logic [15:0] e, input logic c = 1'b0);
        logic [15:0] d;
        logic        ok;
        i_bwsr_host_model.read_reg(a, c, d, ok);
        cmp($sformatf("answer %h", a), 16'h0001, {15'h0000, ok});
        if (!ok) begin
            end_sim();
        end
        cmp($sformatf("register %h", a), e, d);
    endtask

    // One-cycle pulse on the chosen inputs
    task automatic pulse(input logic [14:0] m);
        @(negedge clock_in);
        p = m;
        @(negedge clock_in);
        p = 15'h0000;
    endtask

    // Free-running clock
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    initial begin
        logic [15:0] wexp [5] = '{16'h0200, 16'h0100, 16'h0080, 16'h0010, 16'h0008};
        int          fidx [3] = '{12, 14, 15};
        int          cnt;
        n_mismatch = 0;
        n_tests = 0;
        p = 15'h0000;
        l = 23'h002201;
        swk_count = 6'h00;
        reset_n_in = 1'b0;
        repeat (6) @(negedge clock_in);
        reset_n_in = 1'b1;
        chk(7'h43, 16'h0000);
        chk(7'h44, 16'h0000);
        chk(7'h50, 16'h0000);
        // Device status: counter, serial fail, CRC bits, prior state
        l[8:7] = 2'b11;
        pulse(15'h0001);
        pulse(15'h001d);
        chk(7'h42, 16'h031b);
        pulse(15'h0002);
        chk(7'h42, 16'h0313);
        chk(7'h42, 16'h0313, 1'b1);
        l[5] = 1'b1;
        pulse(15'h0020);
        chk(7'h42, 16'h0290, 1'b1);
        l[6] = 1'b1;
        pulse(15'h0020);
        chk(7'h42, 16'h0250);
        l[8:5] = 4'b0000;
        // Wake flags on their own bits, cleared by read, fail-safe and soft reset
        for (int i = 0; i < 5; i++) begin
            pulse(15'h0100 << i);
            chk(7'h44, wexp[i]);
            chk(7'h44, 16'h0000);
        end
        pulse(15'h1f00);
        pulse(15'h0040);
        chk(7'h44, 16'h0000);
        pulse(15'h1f00);
        pulse(15'h2000);
        chk(7'h44, 16'h0000);
        // Levels follow in each active mode, then hold between samples
        for (int m = 0; m < 4; m++) begin
            l[3:0] = 4'b0001 << m;
            l[22:21] = m[0] ? 2'b01 : 2'b10;
            repeat (5) @(negedge clock_in);
            chk(7'h45, m[0] ? 16'h0008 : 16'h0010);
        end
        l[4:0] = 5'b10000;
        l[22:21] = 2'b11;
        repeat (5) @(negedge clock_in);
        chk(7'h45, 16'h0008);
        pulse(15'h0080);
        repeat (4) @(negedge clock_in);
        chk(7'h45, 16'h0018);
        l[4:0] = 5'b00001;
        // Failure codes; transmitter back only after a recessive spell
        for (int k = 0; k < 3; k++) begin
            l[fidx[k]] = 1'b1;
            l[13] = 1'b0;
            i_bwsr_host_model.dominant(3);
            cmp("transmitter", 16'h0000, {15'h0000, tx_enable_out});
            l[fidx[k]] = 1'b0;
            l[13] = 1'b1;
            cnt = 0;
            while (tx_enable_out !== 1'b1 && cnt < 50) begin
                @(negedge clock_in);
                cnt++;
            end
            cmp("resume wait", 16'h0001, {15'h0000, cnt >= TX_EN && cnt < 50});
            if (cnt == 50) begin
                end_sim();
            end
            chk(7'h43, 16'h0002 * (k + 1));
            chk(7'h43, 16'h0000);
        end
        // Undervoltage seen only while the transceiver is active
        l[16] = 1'b1;
        repeat (3) @(negedge clock_in);
        l[16] = 1'b0;
        chk(7'h43, 16'h0001);
        chk(7'h43, 16'h0000);
        l[9] = 1'b0;
        l[16] = 1'b1;
        repeat (3) @(negedge clock_in);
        l[16] = 1'b0;
        l[9] = 1'b1;
        chk(7'h43, 16'h0000);
        // System error only with selective wake and a count above the limit
        swk_count = 6'h21;
        repeat (2) @(negedge clock_in);
        chk(7'h43, 16'h0000);
        l[17] = 1'b1;
        swk_count = 6'h20;
        repeat (2) @(negedge clock_in);
        chk(7'h43, 16'h0000);
        swk_count = 6'h21;
        repeat (2) @(negedge clock_in);
        swk_count = 6'h00;
        chk(7'h43, 16'h0008);
        // Timeout: blocked clear without interrupt, then interrupt in normal mode
        l[20] = 1'b1;
        l[0] = 1'b0;
        l[19] = 1'b1;
        repeat (3) @(negedge clock_in);
        l[19] = 1'b0;
        chk(7'h43, 16'h0010);
        chk(7'h43, 16'h0010);
        pulse(15'h4000);
        chk(7'h43, 16'h0010);
        chk(7'h43, 16'h0000);
        l[0] = 1'b1;
        l[19] = 1'b1;
        cnt = 0;
        while (interrupt_out_n !== 1'b0 && cnt < 10) begin
            @(negedge clock_in);
            cnt++;
        end
        cmp("interrupt", 16'h0001, {15'h0000, cnt < 10});
        l[19] = 1'b0;
        chk(7'h43, 16'h0010);
        chk(7'h43, 16'h0000);
        end_sim();
    end
endmodule

bind bwsr_status_bank bwsr_checker #(.TX_ENABLE_CYCLES(TX_ENABLE_CYCLES)) i_bwsr_checker (.clock_in, .reset_n_in,
    .read_strobe_in, .address_in, .read_data_out, .read_valid_out, .mode_normal_in, .can_txd_in,
    .selective_wake_enable_in, .can_silence_indication_in, .can_timeout_irq_mask_in, .pin_five_in,
    .interrupt_out_n, .tx_enable_out);
